//--- hdl/scfm_monitor.sv
`timescale 1ns/10ps
// How it works
// - relay-common sense active-high without jumper, active-low with jumper fitted
// - unplugged red harness connector latches a fault and forces flash
// - either red-fail inhibit input active suspends red-fail checking only
// - inhibit input active after 550 ms high, inactive under 250 ms
// - red input on after 500 ms, off when present under 200 ms
// - green and yellow inputs qualified the same way as red
// - red-fail, clearance, dual, harness and watchdog faults latch until front-panel or remote reset
// - red fail after 1000 ms or 1500 ms with no indication on
// - red fail checked only if switch, red gating, no inhibit, relay-common inactive
// - after green, yellow must be on 2.7 s or clearance fault
// - clearance check per switch, off for yellow inhibit, no gating, relay-common
// - two indications on together over 500 ms give dual fault
// - three-colour dual per channel, green-yellow dual for all, gated
// - configuration compared with stored copy; difference faults and flashes card lamp
// - configuration fault cleared only by front reset held three seconds
// - brown-out faults and flashes power lamp 2 Hz, restore restarts the 4 Hz flash interval
// - faults survive a line interruption with the same indications
// - start-up flash interval suspends monitoring, closes relay, power lamp 4 Hz
// - interval ends after 6 s, five watchdog transitions and line restored
// - five transitions missing by ten seconds gives watchdog error fault
// - switch selects standard or compact arrow mode, per-phase monitor enables
// - standard mode takes arrow heads from channels 9-12 and odd greens
module scfm_monitor #(
  parameter int NCH       = scfm_pkg::NCH,
  parameter int MS_CYCLES = scfm_pkg::MS_CYCLES
) (
  input  wire logic               mclk,
  input  wire logic               sys_rst,
  input  wire logic [NCH-1:0]     red_raw,
  input  wire logic [NCH-1:0]     yel_raw,
  input  wire logic [NCH-1:0]     grn_raw,
  input  wire logic               red_enable_raw,
  input  wire logic               inhibit1_raw,
  input  wire logic               inhibit2_raw,
  input  wire logic               relay_common_sense,
  input  wire logic               polarity_jumper,
  input  wire logic               red_harness_connector,
  input  wire logic               watchdog_raw,
  input  wire logic               line_below_dropout,
  input  wire logic               line_above_restore,
  input  wire logic               front_reset_btn,
  input  wire logic               remote_reset,
  input  wire logic [NCH-1:0]     red_fail_en,
  input  wire logic [NCH-1:0]     clearance_en,
  input  wire logic [NCH-1:0]     yellow_inhibit,
  input  wire logic [NCH-1:0]     dual_en,
  input  wire logic               gy_dual_all,
  input  wire logic               red_fail_newer,
  input  wire logic               arrow_turn_compact_mode,
  input  wire logic [3:0]         arrow_phase_en,
  output logic                    relay_flash,
  output logic                    fault_red_fail,
  output logic                    fault_clearance,
  output logic                    fault_dual,
  output logic                    fault_config,
  output logic                    fault_harness,
  output logic                    fault_brownout,
  output logic                    watchdog_error,
  output logic [NCH-1:0]          chan_fail,
  output logic                    power_led,
  output logic                    program_card_led,
  output logic [3:0]              arrow_red,
  output logic [3:0]              arrow_yel,
  output logic [3:0]              arrow_fya,
  output logic [3:0]              arrow_grn
);
  localparam int TW = scfm_pkg::TW;
  localparam int CW = 4 * NCH + 7;

  scfm_time_if tb ();
  logic [3*NCH+1:0]  fld_q;
  logic [1:0]        inh_q;
  logic [NCH-1:0]    r_on;
  logic [NCH-1:0]    y_on;
  logic [NCH-1:0]    g_on;
  logic              red_gate;
  logic              rcs_level;
  logic              rcs_active;
  logic              inhibit_on;
  logic              mon_on;
  logic              clr_req;
  logic [6:0]        ctl_s1_ff;
  logic [6:0]        ctl_s2_ff;
  logic              wd_prev_ff;
  logic [2:0]        wd_cnt_ff;
  logic [TW-1:0]     st_cnt_ff;
  logic [TW-1:0]     hold_cnt_ff;
  scfm_pkg::scfm_state_t state_ff;
  logic [CW-1:0]     cfg_now;
  logic [CW-1:0]     cfg_store_ff;
  logic              cfg_valid_ff;
  logic              cfg_clr;
  logic [TW-1:0]     rf_limit;
  logic [NCH-1:0]    rf_hit;
  logic [NCH-1:0]    cl_hit;
  logic [NCH-1:0]    dl_hit;
  logic [NCH-1:0]    grn_seen_ff;
  logic [NCH-1:0]    y_prev_ff;
  logic [TW-1:0]     rf_cnt_ff [NCH];
  logic [TW-1:0]     yl_cnt_ff [NCH];
  logic [TW-1:0]     dl_cnt_ff [NCH];
  logic              wd_err_ff;
  logic [6:0]        flt_ff;
  logic [NCH-1:0]    chan_fail_ff;
  logic [3:0]        a_red_ff;
  logic [3:0]        a_yel_ff;
  logic [3:0]        a_fya_ff;
  logic [3:0]        a_grn_ff;

  // true when two or more of three indications are on
  function automatic logic two_of_three(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  scfm_timebase #(.MS_CYCLES(MS_CYCLES)) u_tb (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .tb      (tb)
  );

  // field inputs, red gating and relay-common qualified over 500 ms
  scfm_qual #(.W(3 * NCH + 2), .ON_MS(scfm_pkg::FIELD_ON_MS)) u_fld (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .tb      (tb),
    .raw     ({relay_common_sense, red_enable_raw, grn_raw, yel_raw, red_raw}),
    .qual    (fld_q)
  );

  // red-fail inhibit inputs qualified over 550 ms
  scfm_qual #(.W(2), .ON_MS(scfm_pkg::SPEC_ON_MS)) u_inh (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .tb      (tb),
    .raw     ({inhibit2_raw, inhibit1_raw}),
    .qual    (inh_q)
  );

  assign r_on       = fld_q[NCH-1:0];
  assign y_on       = fld_q[2*NCH-1:NCH];
  assign g_on       = fld_q[3*NCH-1:2*NCH];
  assign red_gate   = fld_q[3*NCH];
  // sense is on after qualification; without jumper a high level is active
  assign rcs_level  = fld_q[3*NCH+1];
  assign rcs_active = polarity_jumper ? ~rcs_level : rcs_level;
  assign inhibit_on = |inh_q;
  assign mon_on     = (state_ff == scfm_pkg::scfm_st_run);
  assign rf_limit   = red_fail_newer ? scfm_pkg::RF_NEWER_MS : scfm_pkg::RF_LEGACY_MS;

  // synchronise control levels: watchdog, buttons, line, harness
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      // harness bit idles plugged in, so no false harness fault after reset
      ctl_s1_ff <= 7'h40;
      ctl_s2_ff <= 7'h40;
    end else begin
      ctl_s1_ff <= {red_harness_connector, line_above_restore, line_below_dropout,
                    remote_reset, front_reset_btn, watchdog_raw, 1'b0};
      ctl_s2_ff <= ctl_s1_ff;
    end
  end

  // either reset source clears the ordinary fault latches
  assign clr_req = ctl_s2_ff[2] | ctl_s2_ff[3];

  // per-channel red-fail, clearance and dual timers
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic rf_chk;
    logic cl_chk;
    logic dl_chk;
    logic dual_now;
    assign rf_chk   = mon_on & red_fail_en[g] & red_gate & ~inhibit_on & ~rcs_active;
    assign cl_chk   = mon_on & clearance_en[g] & ~yellow_inhibit[g] & red_gate
                      & ~rcs_active;
    assign dl_chk   = mon_on & red_gate & ~rcs_active;
    assign dual_now = (dual_en[g] & two_of_three(r_on[g], y_on[g], g_on[g]))
                      | (gy_dual_all & y_on[g] & g_on[g]);

    // absence of any indication
    always_ff @(posedge mclk) begin
      if (sys_rst || !rf_chk || r_on[g] || y_on[g] || g_on[g]) begin
        rf_cnt_ff[g] <= '0;
      end else if (tb.ms_tick && rf_cnt_ff[g] < rf_limit) begin
        rf_cnt_ff[g] <= rf_cnt_ff[g] + 1'b1;
      end
    end
    assign rf_hit[g] = rf_chk & (rf_cnt_ff[g] >= rf_limit);

    // yellow duration after a green
    always_ff @(posedge mclk) begin
      if (sys_rst || !y_on[g]) begin
        yl_cnt_ff[g] <= '0;
      end else if (tb.ms_tick && yl_cnt_ff[g] < scfm_pkg::CLEAR_MS) begin
        yl_cnt_ff[g] <= yl_cnt_ff[g] + 1'b1;
      end
    end

    // green arms the check, yellow end or red disarms it
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        grn_seen_ff[g] <= 1'b0;
        y_prev_ff[g]   <= 1'b0;
      end else begin
        y_prev_ff[g] <= y_on[g];
        if (g_on[g]) begin
          grn_seen_ff[g] <= 1'b1;
        end else if ((y_prev_ff[g] && !y_on[g]) || (r_on[g] && !y_on[g])) begin
          grn_seen_ff[g] <= 1'b0;
        end
      end
    end
    // short yellow ends early, missing yellow goes straight to red
    assign cl_hit[g] = cl_chk & grn_seen_ff[g] & ~g_on[g]
                       & ((y_prev_ff[g] & ~y_on[g] & (yl_cnt_ff[g] < scfm_pkg::CLEAR_MS))
                       | (r_on[g] & ~y_on[g] & ~y_prev_ff[g]));

    // overlap of indications
    always_ff @(posedge mclk) begin
      if (sys_rst || !dl_chk || !dual_now) begin
        dl_cnt_ff[g] <= '0;
      end else if (tb.ms_tick && dl_cnt_ff[g] <= scfm_pkg::DUAL_MS) begin
        dl_cnt_ff[g] <= dl_cnt_ff[g] + 1'b1;
      end
    end
    assign dl_hit[g] = dl_chk & (dl_cnt_ff[g] > scfm_pkg::DUAL_MS);
  end

  // start-up flash interval, watchdog transitions and brown-out
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_ff   <= scfm_pkg::scfm_st_flash;
      st_cnt_ff  <= '0;
      wd_cnt_ff  <= '0;
      wd_prev_ff <= 1'b0;
      wd_err_ff  <= 1'b0;
    end else begin
      wd_prev_ff <= ctl_s2_ff[1];
      unique case (state_ff)
        scfm_pkg::scfm_st_flash: begin
          if (tb.ms_tick && st_cnt_ff < scfm_pkg::FLASH_MAX_MS) st_cnt_ff <= st_cnt_ff + 1'b1;
          if (ctl_s2_ff[1] != wd_prev_ff && wd_cnt_ff < scfm_pkg::WD_TRANS) begin
            wd_cnt_ff <= wd_cnt_ff + 1'b1;
          end
          if (ctl_s2_ff[4]) begin
            state_ff <= scfm_pkg::scfm_st_down;
          end else if (st_cnt_ff >= scfm_pkg::FLASH_MIN_MS && wd_cnt_ff >= scfm_pkg::WD_TRANS
                       && ctl_s2_ff[5]) begin
            state_ff <= scfm_pkg::scfm_st_run;
          end else if (st_cnt_ff >= scfm_pkg::FLASH_MAX_MS) begin
            wd_err_ff <= wd_cnt_ff < scfm_pkg::WD_TRANS;
            state_ff  <= scfm_pkg::scfm_st_run;
          end
        end
        scfm_pkg::scfm_st_run: begin
          if (ctl_s2_ff[4]) state_ff <= scfm_pkg::scfm_st_down;
        end
        scfm_pkg::scfm_st_down: begin
          st_cnt_ff <= '0;
          wd_cnt_ff <= '0;
          if (ctl_s2_ff[5]) state_ff <= scfm_pkg::scfm_st_flash;
        end
      endcase
      if (clr_req && state_ff != scfm_pkg::scfm_st_flash) wd_err_ff <= 1'b0;
    end
  end

  // configuration snapshot and front-button hold timer
  assign cfg_now = {red_fail_en, clearance_en, yellow_inhibit, dual_en, gy_dual_all,
                    red_fail_newer, arrow_turn_compact_mode, arrow_phase_en};
  assign cfg_clr = ctl_s2_ff[2] && (hold_cnt_ff >= scfm_pkg::CFG_HOLD_MS);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cfg_valid_ff <= 1'b0;
      cfg_store_ff <= '0;
      hold_cnt_ff  <= '0;
    end else begin
      if (!ctl_s2_ff[2]) begin
        hold_cnt_ff <= '0;
      end else if (tb.ms_tick && hold_cnt_ff < scfm_pkg::CFG_HOLD_MS) begin
        hold_cnt_ff <= hold_cnt_ff + 1'b1;
      end
      if (!cfg_valid_ff || cfg_clr) begin
        cfg_store_ff <= cfg_now;
        cfg_valid_ff <= 1'b1;
      end
    end
  end

  // fault latches: a set in the same cycle as a clear wins; a brown-out keeps them
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flt_ff       <= '0;
      chan_fail_ff <= '0;
    end else begin
      if (clr_req) begin
        flt_ff[0]    <= 1'b0;
        flt_ff[1]    <= 1'b0;
        flt_ff[2]    <= 1'b0;
        flt_ff[4]    <= 1'b0;
        chan_fail_ff <= '0;
      end
      if (cfg_clr) flt_ff[3] <= 1'b0;
      if (|rf_hit) flt_ff[0] <= 1'b1;
      if (|cl_hit) flt_ff[1] <= 1'b1;
      if (|dl_hit) flt_ff[2] <= 1'b1;
      if (cfg_valid_ff && tb.ms_tick && cfg_now != cfg_store_ff) flt_ff[3] <= 1'b1;
      if (!ctl_s2_ff[6] && cfg_valid_ff) flt_ff[4] <= 1'b1;
      flt_ff[5] <= (state_ff == scfm_pkg::scfm_st_down);
      chan_fail_ff <= (clr_req ? '0 : chan_fail_ff) | rf_hit | cl_hit | dl_hit;
    end
  end

  // arrow-turn head mapping per phase
  for (genvar p = 0; p < scfm_pkg::NPH; p++) begin : g_arw
    always_ff @(posedge mclk) begin
      if (sys_rst || !arrow_phase_en[p]) begin
        a_red_ff[p] <= 1'b0;
        a_yel_ff[p] <= 1'b0;
        a_fya_ff[p] <= 1'b0;
        a_grn_ff[p] <= 1'b0;
      end else if (!arrow_turn_compact_mode) begin
        a_red_ff[p] <= r_on[scfm_pkg::ARW_STD_BASE + p];
        a_yel_ff[p] <= y_on[scfm_pkg::ARW_STD_BASE + p];
        a_fya_ff[p] <= g_on[scfm_pkg::ARW_STD_BASE + p];
        a_grn_ff[p] <= g_on[2 * p];
      end else begin
        a_red_ff[p] <= r_on[2 * p];
        a_yel_ff[p] <= y_on[2 * p];
        a_fya_ff[p] <= g_on[2 * p];
        a_grn_ff[p] <= (p % 2 != 0) ? y_on[scfm_pkg::ARW_CMP_BASE + p / 2]
                                    : g_on[scfm_pkg::ARW_CMP_BASE + p / 2];
      end
    end
  end

  // outputs and indicators
  assign fault_red_fail   = flt_ff[0];
  assign fault_clearance  = flt_ff[1];
  assign fault_dual       = flt_ff[2];
  assign fault_config     = flt_ff[3];
  assign fault_harness    = flt_ff[4];
  assign fault_brownout   = flt_ff[5];
  assign watchdog_error   = wd_err_ff;
  assign chan_fail        = chan_fail_ff;
  assign relay_flash      = ~mon_on | (|flt_ff) | wd_err_ff;
  assign power_led        = (state_ff == scfm_pkg::scfm_st_down)  ? tb.blink_2hz :
                            (state_ff == scfm_pkg::scfm_st_flash) ? tb.blink_4hz : 1'b1;
  assign program_card_led = flt_ff[3] & tb.blink_2hz;
  assign arrow_red        = a_red_ff;
  assign arrow_yel        = a_yel_ff;
  assign arrow_fya        = a_fya_ff;
  assign arrow_grn        = a_grn_ff;
endmodule

//--- hdl/scfm_pkg.sv
package scfm_pkg;
  // channel count and width of every millisecond counter
  localparam int              NCH          = 18;
  localparam int              NPH          = 4;
  localparam int              TW           = 14;
  // system clock rate and the cycles in one millisecond tick
  localparam int              CLK_HZ       = 32'h05F5_E100;
  localparam int              MS_PER_S     = 32'h0000_03E8;
  localparam int              MS_CYCLES    = CLK_HZ / MS_PER_S;
  // qualification times in ms
  localparam logic [TW-1:0]   FIELD_ON_MS  = 14'h01F4;
  localparam logic [TW-1:0]   SPEC_ON_MS   = 14'h0226;
  // fault times in ms
  localparam logic [TW-1:0]   RF_LEGACY_MS = 14'h03E8;
  localparam logic [TW-1:0]   RF_NEWER_MS  = 14'h05DC;
  localparam logic [TW-1:0]   CLEAR_MS     = 14'h0A8C;
  localparam logic [TW-1:0]   DUAL_MS      = 14'h01F4;
  localparam logic [TW-1:0]   CFG_HOLD_MS  = 14'h0BB8;
  // start-up flash interval bounds in ms and watchdog transitions needed
  localparam logic [TW-1:0]   FLASH_MIN_MS = 14'h1770;
  localparam logic [TW-1:0]   FLASH_MAX_MS = 14'h2710;
  localparam logic [2:0]      WD_TRANS     = 3'h5;
  // half periods of the 2 Hz and 4 Hz indicator patterns in ms
  localparam logic [TW-1:0]   HALF_2HZ_MS  = 14'h00FA;
  localparam logic [TW-1:0]   HALF_4HZ_MS  = 14'h007D;
  // channel index bases for the arrow-turn mapping
  localparam int              ARW_STD_BASE = 8;
  localparam int              ARW_CMP_BASE = 8;

  typedef enum logic [1:0] {
    scfm_st_flash,
    scfm_st_run,
    scfm_st_down
  } scfm_state_t;
endpackage

//--- hdl/scfm_time_if.sv
`timescale 1ns/10ps
interface scfm_time_if;
  logic ms_tick;
  logic blink_2hz;
  logic blink_4hz;
  modport gen (output ms_tick, output blink_2hz, output blink_4hz);
  modport sink (input ms_tick, input blink_2hz, input blink_4hz);
endinterface

//--- hdl/scfm_timebase.sv
`timescale 1ns/10ps
module scfm_timebase #(
  parameter int MS_CYCLES = scfm_pkg::MS_CYCLES
) (
  input  wire logic  mclk,
  input  wire logic  sys_rst,
  scfm_time_if.gen   tb
);
  logic [31:0]               div_ff;
  logic [scfm_pkg::TW-1:0]   b2_ff;
  logic [scfm_pkg::TW-1:0]   b4_ff;
  logic                      tick_ff;
  logic                      blk2_ff;
  logic                      blk4_ff;

  // millisecond tick from the system clock
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      div_ff  <= 32'h0000_0000;
      tick_ff <= 1'b0;
    end else if (div_ff == 32'(MS_CYCLES - 1)) begin
      div_ff  <= 32'h0000_0000;
      tick_ff <= 1'b1;
    end else begin
      div_ff  <= div_ff + 32'h0000_0001;
      tick_ff <= 1'b0;
    end
  end

  // 2 Hz and 4 Hz square waves, 50% duty
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      b2_ff   <= '0;
      b4_ff   <= '0;
      blk2_ff <= 1'b0;
      blk4_ff <= 1'b0;
    end else if (tick_ff) begin
      b2_ff <= (b2_ff == scfm_pkg::HALF_2HZ_MS - 1'b1) ? '0 : b2_ff + 1'b1;
      b4_ff <= (b4_ff == scfm_pkg::HALF_4HZ_MS - 1'b1) ? '0 : b4_ff + 1'b1;
      if (b2_ff == scfm_pkg::HALF_2HZ_MS - 1'b1) blk2_ff <= ~blk2_ff;
      if (b4_ff == scfm_pkg::HALF_4HZ_MS - 1'b1) blk4_ff <= ~blk4_ff;
    end
  end

  assign tb.ms_tick   = tick_ff;
  assign tb.blink_2hz = blk2_ff;
  assign tb.blink_4hz = blk4_ff;
endmodule

//--- hdl/scfm_qual.sv
`timescale 1ns/10ps
module scfm_qual #(
  parameter int                      W     = 1,
  parameter logic [scfm_pkg::TW-1:0] ON_MS = scfm_pkg::FIELD_ON_MS
) (
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  scfm_time_if.sink          tb,
  input  wire logic [W-1:0]  raw,
  output logic      [W-1:0]  qual
);
  logic [W-1:0]              s1_ff;
  logic [W-1:0]              s2_ff;
  logic [W-1:0]              q_ff;
  logic [scfm_pkg::TW-1:0]   cnt_ff [W];

  // two-stage synchroniser
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
    end
  end

  // on only after the level has lasted ON_MS, off as soon as it drops
  for (genvar g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge mclk) begin
      if (sys_rst || !s2_ff[g]) begin
        cnt_ff[g] <= '0;
        q_ff[g]   <= 1'b0;
      end else if (cnt_ff[g] >= ON_MS) begin
        q_ff[g] <= 1'b1;
      end else if (tb.ms_tick) begin
        cnt_ff[g] <= cnt_ff[g] + 1'b1;
      end
    end
  end

  assign qual = q_ff;
endmodule

//--- dv/scfm_field_model.sv
`timescale 1ns/10ps
module scfm_field_model (
  input  wire logic        mclk,
  input  wire logic [17:0] red_on,
  input  wire logic [17:0] grn_on,
  input  wire logic        wd_run,
  output logic      [17:0] red_raw,
  output logic      [17:0] yel_raw,
  output logic      [17:0] grn_raw,
  output logic             watchdog_raw
);
  logic [5:0] wd_cnt_ff = 6'h00;
  initial watchdog_raw = 1'b0;
  // lamp drives follow the controller; yellow stays dark, so a clearance always has its yellow missing
  assign red_raw = red_on;
  assign grn_raw = grn_on;
  assign yel_raw = 18'h0_0000;
  // heartbeat toggles every 50 cycles while the controller runs, frozen otherwise
  always @(negedge mclk) begin
    wd_cnt_ff <= (wd_run && wd_cnt_ff != 6'h31) ? wd_cnt_ff + 6'h01 : 6'h00;
    if (wd_run && wd_cnt_ff == 6'h31) begin
      watchdog_raw <= ~watchdog_raw;
    end
  end
endmodule

//--- dv/scfm_monitor_checker.sv
`timescale 1ns/10ps
module scfm_monitor_checker #(
  parameter int NCH       = 18,
  parameter int MS_CYCLES = 10
) (
  input wire logic           mclk,
  input wire logic           sys_rst,
  input wire logic           red_enable_raw,
  input wire logic           front_reset_btn,
  input wire logic           remote_reset,
  input wire logic           relay_flash,
  input wire logic           fault_red_fail,
  input wire logic           fault_clearance,
  input wire logic           fault_dual,
  input wire logic           fault_config,
  input wire logic           fault_harness,
  input wire logic           fault_brownout,
  input wire logic           watchdog_error,
  input wire logic [NCH-1:0] chan_fail,
  input wire logic           power_led
);
  localparam int FLASH_MIN_CYC = 5999 * MS_CYCLES;
  localparam int WD_MIN_CYC    = 9499 * MS_CYCLES;
  logic [31:0] up_cyc_ff;
  logic [31:0] nxt_up_cyc;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // cycles since reset release, saturating
  assign nxt_up_cyc = (&up_cyc_ff) ? up_cyc_ff : up_cyc_ff + 32'h0000_0001;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      up_cyc_ff <= 32'h0000_0000;
    end else begin
      up_cyc_ff <= nxt_up_cyc;
    end
  end
  // reset requests absent long enough to have passed the synchronisers
  sequence s_no_clear;
    (!front_reset_btn && !remote_reset) [*5];
  endsequence
  sequence s_no_front;
    !front_reset_btn [*5];
  endsequence
  property p_any_flash;
    (fault_red_fail || fault_clearance || fault_dual || fault_config || fault_harness
      || fault_brownout || watchdog_error) |-> relay_flash;
  endproperty
  property p_rf_hold;
    s_no_clear ##0 fault_red_fail |=> fault_red_fail;
  endproperty
  property p_cfg_hold;
    s_no_front ##0 fault_config |=> fault_config;
  endproperty
  property p_gate;
    !red_enable_raw [*8] |-> !$rose(fault_red_fail) && !$rose(fault_dual)
      && !$rose(fault_clearance);
  endproperty
  property p_chan;
    $rose(fault_red_fail) |-> chan_fail != '0;
  endproperty
  property p_flash_min;
    up_cyc_ff < FLASH_MIN_CYC |-> relay_flash;
  endproperty
  property p_wd_min;
    watchdog_error |-> up_cyc_ff >= WD_MIN_CYC;
  endproperty
  property p_power_steady;
    !relay_flash [*2] |-> power_led;
  endproperty
  a_any_flash: assert property (p_any_flash)
    else $error("fault without relay flash");
  a_rf_hold: assert property (p_rf_hold)
    else $error("red fail cleared without reset");
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("config fault cleared without front button");
  a_gate: assert property (p_gate)
    else $error("fault raised with red gating off");
  a_chan: assert property (p_chan)
    else $error("red fail without channel mark");
  a_flash_min: assert property (p_flash_min)
    else $error("flash interval ended early");
  a_wd_min: assert property (p_wd_min)
    else $error("watchdog error too early");
  a_power_steady: assert property (p_power_steady)
    else $error("power lamp not steady in run");
endmodule
bind scfm_monitor scfm_monitor_checker #(.NCH(NCH), .MS_CYCLES(MS_CYCLES)) u_chk (
  .mclk, .sys_rst, .red_enable_raw, .front_reset_btn, .remote_reset, .relay_flash,
  .fault_red_fail, .fault_clearance, .fault_dual, .fault_config, .fault_harness,
  .fault_brownout, .watchdog_error, .chan_fail, .power_led);

//--- dv/testbench.sv
`timescale 1ns/10ps
module testbench;
  localparam int MSC = 2;
  logic        mclk, sys_rst, wd_run, watchdog_raw, red_enable_raw, inhibit1_raw, inhibit2_raw;
  logic        red_harness_connector, line_below_dropout, line_above_restore;
  logic        front_reset_btn, remote_reset, gy_dual_all;
  logic [17:0] red_on, grn_on, red_raw, yel_raw, grn_raw, chan_fail;
  logic        relay_flash, fault_red_fail, fault_clearance, fault_dual, fault_config;
  logic        fault_harness, fault_brownout, watchdog_error, power_led, program_card_led;
  // static switches: the config compare must see no change
  logic [17:0] chan_sw = 18'h0_0001;
  logic [3:0]  arrow_red, arrow_grn;
  int          fail_count = 0;
  int          compares = 0;
  int          cycles = 0;

  scfm_field_model u_field (.mclk, .red_on, .grn_on, .wd_run, .red_raw, .yel_raw, .grn_raw,
    .watchdog_raw);
  scfm_monitor #(.MS_CYCLES(MSC)) DUT (
    .mclk, .sys_rst, .red_raw, .yel_raw, .grn_raw, .red_enable_raw, .inhibit1_raw,
    .inhibit2_raw, .relay_common_sense(1'b0), .polarity_jumper(1'b0),
    .red_harness_connector, .watchdog_raw, .line_below_dropout, .line_above_restore,
    .front_reset_btn, .remote_reset, .red_fail_en(chan_sw),
    .clearance_en(chan_sw << 2), .yellow_inhibit(chan_sw), .dual_en(chan_sw),
    .gy_dual_all, .red_fail_newer(1'b0), .arrow_turn_compact_mode(1'b0),
    .arrow_phase_en(4'hd), .relay_flash, .fault_red_fail, .fault_clearance, .fault_dual,
    .fault_config, .fault_harness, .fault_brownout, .watchdog_error, .chan_fail, .power_led,
    .program_card_led, .arrow_red, .arrow_yel(), .arrow_fya(), .arrow_grn);

  // clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 80000) begin
      fail_count++;
      $display("Error timeout expected finish seen hang");
      print_verdict();
    end
  end

  task automatic chk(string nm, logic [17:0] exp, logic [17:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wait_ms(int n);
    repeat (n * MSC) @(negedge mclk);
  endtask
  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (6) @(negedge mclk);
    sys_rst = 1'b0;
    @(negedge mclk);
  endtask
  task automatic pulse_remote();
    remote_reset = 1'b1;
    wait_ms(2);
    remote_reset = 1'b0;
    wait_ms(2);
  endtask
  // counts power lamp (or program card lamp) edges over one second
  task automatic count_toggles(int exp, bit card);
    int   n;
    logic prev;
    n = 0;
    prev = card ? program_card_led : power_led;
    repeat (1000 * MSC) begin
      @(negedge mclk);
      if ((card ? program_card_led : power_led) !== prev) n++;
      prev = card ? program_card_led : power_led;
    end
    chk("lamp toggles", 18'(exp), 18'(n));
  endtask
  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    {sys_rst, wd_run, red_harness_connector, line_above_restore} = 4'hf;
    {red_enable_raw, inhibit1_raw, inhibit2_raw, line_below_dropout} = 4'h0;
    {front_reset_btn, remote_reset, gy_dual_all} = 3'h0;
    red_on = 18'h3_FFFF;
    grn_on = 18'h0_0000;
    do_reset();
    chk("relay_flash", 18'h1, 18'(relay_flash));
    wait_ms(1000);
    red_enable_raw = 1'b1;
    wait_ms(4900);
    chk("relay_flash", 18'h1, 18'(relay_flash));
    wait_ms(200);
    chk("relay_flash", 18'h0, 18'(relay_flash));
    chk("power_led", 18'h1, 18'(power_led));
    chk("arrow_red", 18'hd, 18'(arrow_red));
    red_on[0] = 1'b0;
    wait_ms(700);
    chk("fault_red_fail", 18'h0, 18'(fault_red_fail));
    wait_ms(400);
    chk("fault_red_fail", 18'h1, 18'(fault_red_fail));
    chk("chan_fail", 18'h1, chan_fail);
    red_on[0] = 1'b1;
    wait_ms(600);
    chk("relay_flash", 18'h1, 18'(relay_flash));
    pulse_remote();
    chk("fault_red_fail", 18'h0, 18'(fault_red_fail));
    inhibit1_raw = 1'b1;
    wait_ms(600);
    red_on[0] = 1'b0;
    wait_ms(600);
    // hand over to the second inhibit; the gap while it qualifies stays under 1000 ms
    {inhibit1_raw, inhibit2_raw} = 2'h1;
    wait_ms(1200);
    chk("fault_red_fail", 18'h0, 18'(fault_red_fail));
    red_on[0] = 1'b1;
    wait_ms(600);
    inhibit2_raw = 1'b0;
    grn_on[0] = 1'b1;
    wait_ms(600);
    chk("arrow_grn", 18'h1, 18'(arrow_grn));
    grn_on[0] = 1'b0;
    wait_ms(20);
    chk("fault_dual", 18'h0, 18'(fault_dual));
    grn_on[0] = 1'b1;
    wait_ms(1100);
    chk("fault_dual", 18'h1, 18'(fault_dual));
    grn_on[0] = 1'b0;
    pulse_remote();
    grn_on[2] = 1'b1;
    wait_ms(600);
    grn_on[2] = 1'b0;
    wait_ms(600);
    chk("fault_clearance", 18'h1, 18'(fault_clearance));
    pulse_remote();
    gy_dual_all = 1'b1;
    wait_ms(5);
    chk("fault_config", 18'h1, 18'(fault_config));
    pulse_remote();
    chk("fault_config", 18'h1, 18'(fault_config));
    count_toggles(4, 1'b1);
    front_reset_btn = 1'b1;
    wait_ms(3100);
    front_reset_btn = 1'b0;
    wait_ms(2);
    chk("fault_config", 18'h0, 18'(fault_config));
    {line_below_dropout, line_above_restore} = 2'h2;
    wait_ms(10);
    chk("fault_brownout", 18'h1, 18'(fault_brownout));
    count_toggles(4, 1'b0);
    {line_below_dropout, line_above_restore} = 2'h1;
    wait_ms(10);
    count_toggles(8, 1'b0);
    wait_ms(5200);
    chk("relay_flash", 18'h0, 18'(relay_flash));
    red_harness_connector = 1'b0;
    wait_ms(5);
    chk("fault_harness", 18'h1, 18'(fault_harness));
    red_harness_connector = 1'b1;
    wd_run = 1'b0;
    do_reset();
    wait_ms(10600);
    chk("watchdog_error", 18'h1, 18'(watchdog_error));
    print_verdict();
  end
endmodule
